// file: rtl/nvm_ctrl_pkg.sv
package nvm_ctrl_pkg;
	localparam int PAGE_COUNT = 16;
	localparam int PAGE_BYTES = 8;
	localparam int ARRAY_BYTES = 128;
	localparam int ADDR_W = 7;
	localparam int PAGE_W = 4;
	localparam logic [6:0] CRC_BYTE_ADDR = 7'h7f;
	localparam logic [6:0] CFG_FAULT_LEVEL_ADDR = 7'h7c;
	localparam logic [6:0] CFG_DIAG_ON_ADDR = 7'h7d;
	localparam logic [6:0] CFG_SENSOR_ADDR = 7'h7e;
	localparam logic [3:0] LAST_PAGE = 4'hf;
	localparam logic [7:0] CRC_SEED = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] ERASED_BYTE = 8'h00;
	localparam logic [7:0] ARRAY_RESET = 8'h00;
	localparam logic [7:0] REG_PAGE_SELECT = 8'h00;
	localparam logic [7:0] REG_NVM_CTRL = 8'h01;
	localparam logic [7:0] REG_NVM_STATUS = 8'h02;
	localparam logic [7:0] REG_CRC_CTRL = 8'h03;
	localparam logic [7:0] REG_CRC_STATUS = 8'h04;
	localparam logic [7:0] REG_SENSOR_CFG = 8'h05;
	localparam logic [7:0] REG_OV_LIMIT = 8'h06;
	localparam logic [7:0] REG_UV_LIMIT = 8'h07;
	localparam logic [7:0] REG_FAULT_STATUS = 8'h08;
	localparam logic [7:0] REG_CACHE_BASE = 8'h10;
	localparam int CTRL_ERASE_BIT = 0;
	localparam int CTRL_PAGE_WRITE_BIT = 1;
	localparam int CTRL_ERASE_WRITE_BIT = 2;
	localparam int ST_ERASE_BUSY_BIT = 0;
	localparam int ST_PROG_BUSY_BIT = 1;
	localparam int ST_ERASE_DONE_BIT = 2;
	localparam int ST_PROG_DONE_BIT = 3;
	localparam int ST_CACHE_SHORT_BIT = 4;
	localparam int ST_CACHE_FULL_BIT = 5;
	localparam int CRC_RECOMPUTE_BIT = 0;
	localparam int CRC_BUSY_BIT = 0;
	localparam int CRC_MATCH_BIT = 1;
	localparam int CRC_PU_DONE_BIT = 2;
	localparam int CRC_CORRUPT_BIT = 3;
	localparam int CFG_PD_LO_BIT = 0;
	localparam int CFG_PD_HI_BIT = 1;
	localparam int CFG_LEVEL_LSB = 2;
	localparam int CFG_PRESS_PD_OFF_BIT = 5;
	localparam int CFG_TEMP_PU_OFF_BIT = 6;
	localparam logic [7:0] OV_LIMIT_RESET = 8'hff;
	localparam logic [7:0] UV_LIMIT_RESET = 8'h00;
	localparam int ERASE_CYCLES = 64;
	localparam int PROGRAM_CYCLES = 64;
	localparam int CLK_MHZ = 200;
	localparam int CRC_DEADLINE_US = 340;
	localparam int CRC_DEADLINE_CYCLES = CRC_DEADLINE_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG = 3'b100
	} nvm_state_e;

	function automatic logic [7:0] crc8_next(input logic [7:0] crc,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage

// file: rtl/array_crc_walker.sv
`timescale 1ns/1ps
module array_crc_walker
	import nvm_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] byte_in,
	output logic [6:0] byte_index,
	output logic busy,
	output logic done,
	output logic [7:0] crc_out
);
	logic [7:0] acc;

	assign crc_out = acc;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			byte_index <= 7'h00;
			acc <= CRC_SEED;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				byte_index <= 7'h00;
				acc <= CRC_SEED; // R11
			end else if (busy) begin
				acc <= crc8_next(acc, byte_in); // R11 R22
				if (byte_index == CRC_BYTE_ADDR - 7'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					byte_index <= byte_index + 7'h01;
				end
			end
		end
	end
endmodule // array_crc_walker

// file: rtl/nvm_page_ctrl.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// R01 - array is sixteen pages of eight bytes, seven-bit byte address
// R02 - writes go only through the cache; reads return array bytes directly
// R03 - software picks the page with the upper four address bits first
// R04 - software fills all eight cache bytes before a page program
// R05 - combined command erases the page then programs it from the cache
// R06 - erase bit erases; page write bit later programs the erased page
// R07 - erase and program progress shown in a pollable status register
// R08 - last array byte holds the checksum over the array
// R09 - programming the last byte recomputes and compares the checksum
// R10 - recompute bit starts a check; busy and match bits report it
// R11 - accumulator starts at all ones, updated once per byte by xor
// R12 - power-up checksum check finishes within 340 us
// R13 - compensation timing or checksum error disables dac, resets comp
// R14 - corrupted array or zero checksum forces dac code to zero
// R15 - supply or signal chain fault drives dac to stored fault level
// R16 - nonzero stored diagnostics setting enables responses, zero disables
// R17 - analog, digital, bridge, oscillator rails and reference monitored
// R18 - pressure pin codes compared with programmable over and under limits
// R19 - config bits 0-1 pick pulldown, bits 2-4 pick detect threshold
// R20 - config bit 5 set switches off pressure input pulldowns
// R21 - config bit 6 set switches off temperature input pullups
// R22 - checksum is crc-8 with polynomial x^8+x^2+x+1
// R23 - command bits self-clear at finish; busy covers whole operation
module nvm_page_ctrl
	import nvm_ctrl_pkg::*;
#(
	parameter int ERASE_TIME = ERASE_CYCLES,
	parameter int PROGRAM_TIME = PROGRAM_CYCLES,
	parameter int CRC_DEADLINE = CRC_DEADLINE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic comp_timing_err,
	input wire logic comp_checksum_err,
	input wire logic analog_rail_fault,
	input wire logic digital_rail_fault,
	input wire logic bridge_supply_fault,
	input wire logic osc_supply_fault,
	input wire logic reference_fault,
	input wire logic [7:0] press_in_pos,
	input wire logic [7:0] press_in_neg,
	output logic dac_enable,
	output logic comp_reset,
	output logic dac_code_zero,
	output logic dac_fault_drive,
	output logic [7:0] dac_fault_level,
	output logic pulldown_sel_lo,
	output logic pulldown_sel_hi,
	output logic [2:0] open_detect_level,
	output logic press_pulldown_off,
	output logic temp_pullup_off
);
	logic [7:0] array_mem [ARRAY_BYTES];
	logic [7:0] cache [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] cache_fill;
	logic [PAGE_W-1:0] page_sel;
	nvm_state_e state;
	logic [15:0] op_cnt;
	logic erase_pend;
	logic prog_pend;
	logic combo_pend;
	logic erase_done;
	logic prog_done;
	logic cache_short;
	logic crc_pend;
	logic crc_match;
	logic crc_corrupt;
	logic pu_done;
	logic pu_start;
	logic [17:0] pu_cnt;
	logic [7:0] ov_limit;
	logic [7:0] uv_limit;
	logic crc_start;
	logic crc_busy;
	logic crc_done;
	logic [6:0] crc_index;
	logic [7:0] crc_value;
	logic cache_full;
	logic idle_free;
	logic start_erase;
	logic start_prog;
	logic refuse;
	logic op_end;
	logic last_page_prog;
	logic wr_cache;
	logic [7:0] next_rdata;
	logic [4:0] supply_faults;
	logic [1:0] chain_faults;
	logic diag_on;
	logic [7:0] sensor_cfg;

	function automatic logic [15:0] cycles_m1(input int n);
		return (n < 1) ? 16'h0000 : 16'(n - 1);
	endfunction

	function automatic logic [6:0] byte_addr(input logic [3:0] page,
		input int offs);
		return {page, 3'(offs)}; // R01
	endfunction

	assign cache_full = &cache_fill;
	assign idle_free = (state == ST_IDLE) && !crc_busy && !crc_start;
	assign refuse = idle_free && (prog_pend || combo_pend) && !cache_full;
	assign start_erase = idle_free && (erase_pend || (combo_pend && cache_full));
	assign start_prog = idle_free && prog_pend && cache_full;
	assign op_end = (state != ST_IDLE) && (op_cnt == 16'h0000);
	assign last_page_prog = op_end && (state == ST_PROG) &&
		(page_sel == LAST_PAGE);
	assign wr_cache = reg_wr && (reg_addr[7:3] == REG_CACHE_BASE[7:3]) &&
		(state == ST_IDLE);
	assign crc_start = (pu_start || crc_pend) && (state == ST_IDLE) &&
		!crc_busy;
	assign sensor_cfg = array_mem[CFG_SENSOR_ADDR];
	assign diag_on = array_mem[CFG_DIAG_ON_ADDR] != 8'h00; // R16
	assign supply_faults = {analog_rail_fault, digital_rail_fault,
		bridge_supply_fault, osc_supply_fault, reference_fault}; // R17
	assign chain_faults[0] = (press_in_pos > ov_limit) ||
		(press_in_neg > ov_limit); // R18
	assign chain_faults[1] = (press_in_pos < uv_limit) ||
		(press_in_neg < uv_limit); // R18

	array_crc_walker u_crc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(crc_start),
		.byte_in(array_mem[crc_index]),
		.byte_index(crc_index),
		.busy(crc_busy),
		.done(crc_done),
		.crc_out(crc_value)
	);

	// page select and cache
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			page_sel <= 4'h0;
			cache_fill <= '0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				cache[i] <= 8'h00;
			end
		end else begin
			if (reg_wr && reg_addr == REG_PAGE_SELECT && state == ST_IDLE) begin
				page_sel <= reg_wdata[PAGE_W-1:0]; // R03
			end
			if (op_end && state == ST_PROG) begin
				cache_fill <= '0;
			end else if (wr_cache) begin
				cache[reg_addr[2:0]] <= reg_wdata; // R02
				cache_fill[reg_addr[2:0]] <= 1'b1; // R04
			end
		end
	end

	// command bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			erase_pend <= 1'b0;
			prog_pend <= 1'b0;
			combo_pend <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == REG_NVM_CTRL &&
				!(erase_pend || prog_pend || combo_pend)) begin
				erase_pend <= reg_wdata[CTRL_ERASE_BIT]; // R06
				prog_pend <= reg_wdata[CTRL_PAGE_WRITE_BIT] &&
					!reg_wdata[CTRL_ERASE_BIT]; // R06
				combo_pend <= reg_wdata[CTRL_ERASE_WRITE_BIT] &&
					!reg_wdata[CTRL_ERASE_BIT] &&
					!reg_wdata[CTRL_PAGE_WRITE_BIT]; // R05
			end else if (refuse) begin
				prog_pend <= 1'b0;
				combo_pend <= 1'b0;
			end else if (op_end && state == ST_ERASE && erase_pend) begin
				erase_pend <= 1'b0; // R23
			end else if (op_end && state == ST_PROG) begin
				prog_pend <= 1'b0; // R23
				combo_pend <= 1'b0; // R23
			end
		end
	end

	// erase and program sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			op_cnt <= 16'h0000;
			erase_done <= 1'b0;
			prog_done <= 1'b0;
			cache_short <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_erase) begin
						state <= ST_ERASE;
						op_cnt <= cycles_m1(ERASE_TIME);
						erase_done <= 1'b0;
						prog_done <= 1'b0;
						cache_short <= 1'b0;
					end else if (start_prog) begin
						state <= ST_PROG;
						op_cnt <= cycles_m1(PROGRAM_TIME);
						prog_done <= 1'b0;
						cache_short <= 1'b0;
					end else if (refuse) begin
						cache_short <= 1'b1; // R04
					end
				end
				ST_ERASE: begin
					if (op_cnt != 16'h0000) begin
						op_cnt <= op_cnt - 16'h0001;
					end else begin
						erase_done <= 1'b1; // R07
						if (combo_pend) begin
							state <= ST_PROG; // R05
							op_cnt <= cycles_m1(PROGRAM_TIME);
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_PROG: begin
					if (op_cnt != 16'h0000) begin
						op_cnt <= op_cnt - 16'h0001;
					end else begin
						prog_done <= 1'b1; // R07
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// array storage
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < ARRAY_BYTES; i++) begin
				array_mem[i] <= ARRAY_RESET;
			end
		end else if (op_end) begin
			for (int j = 0; j < PAGE_BYTES; j++) begin
				if (state == ST_ERASE) begin
					array_mem[byte_addr(page_sel, j)] <= ERASED_BYTE; // R05 R06
				end else begin
					array_mem[byte_addr(page_sel, j)] <= cache[j]; // R02 R06
				end
			end
		end
	end

	// checksum control and result
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			crc_pend <= 1'b0;
			crc_match <= 1'b0;
			crc_corrupt <= 1'b0;
			pu_done <= 1'b0;
			pu_start <= 1'b1;
			pu_cnt <= '0;
		end else begin
			if (last_page_prog || (reg_wr && reg_addr == REG_CRC_CTRL &&
				reg_wdata[CRC_RECOMPUTE_BIT])) begin
				crc_pend <= 1'b1; // R09 R10
			end else if (crc_start) begin
				crc_pend <= 1'b0; // R23
			end
			if (crc_start) begin
				pu_start <= 1'b0;
			end
			if (!pu_done && pu_cnt != 18'(CRC_DEADLINE)) begin
				pu_cnt <= pu_cnt + 18'h00001;
			end
			if (crc_done) begin
				crc_match <= crc_value == array_mem[CRC_BYTE_ADDR]; // R08 R09
				crc_corrupt <= (crc_value != array_mem[CRC_BYTE_ADDR]) ||
					(array_mem[CRC_BYTE_ADDR] == 8'h00); // R14
				pu_done <= 1'b1;
			end else if (!pu_done && pu_cnt == 18'(CRC_DEADLINE)) begin
				crc_corrupt <= 1'b1; // R12
			end
		end
	end

	// limits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ov_limit <= OV_LIMIT_RESET;
			uv_limit <= UV_LIMIT_RESET;
		end else if (reg_wr) begin
			if (reg_addr == REG_OV_LIMIT) begin
				ov_limit <= reg_wdata; // R18
			end
			if (reg_addr == REG_UV_LIMIT) begin
				uv_limit <= reg_wdata; // R18
			end
		end
	end

	// fault responses and stored config outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dac_enable <= 1'b0;
			comp_reset <= 1'b1;
			dac_code_zero <= 1'b1;
			dac_fault_drive <= 1'b0;
			dac_fault_level <= 8'h00;
			pulldown_sel_lo <= 1'b0;
			pulldown_sel_hi <= 1'b0;
			open_detect_level <= 3'h0;
			press_pulldown_off <= 1'b0;
			temp_pullup_off <= 1'b0;
		end else begin
			dac_enable <= !(diag_on && (comp_timing_err ||
				comp_checksum_err)); // R13
			comp_reset <= diag_on && (comp_timing_err ||
				comp_checksum_err); // R13
			dac_code_zero <= diag_on && (crc_corrupt || !pu_done); // R14
			dac_fault_drive <= diag_on && ((|supply_faults) ||
				(|chain_faults)); // R15
			dac_fault_level <= array_mem[CFG_FAULT_LEVEL_ADDR]; // R15
			pulldown_sel_lo <= sensor_cfg[CFG_PD_LO_BIT]; // R19
			pulldown_sel_hi <= sensor_cfg[CFG_PD_HI_BIT]; // R19
			open_detect_level <= sensor_cfg[CFG_LEVEL_LSB +: 3]; // R19
			press_pulldown_off <= sensor_cfg[CFG_PRESS_PD_OFF_BIT]; // R20
			temp_pullup_off <= sensor_cfg[CFG_TEMP_PU_OFF_BIT]; // R21
		end
	end

	// register read mux
	always_comb begin
		next_rdata = 8'h00;
		if (reg_addr[7]) begin
			next_rdata = array_mem[reg_addr[6:0]]; // R02
		end else if (reg_addr[7:3] == REG_CACHE_BASE[7:3]) begin
			next_rdata = cache[reg_addr[2:0]];
		end else begin
			case (reg_addr)
				REG_PAGE_SELECT: next_rdata = {4'h0, page_sel};
				REG_NVM_CTRL: begin
					next_rdata[CTRL_ERASE_BIT] = erase_pend; // R23
					next_rdata[CTRL_PAGE_WRITE_BIT] = prog_pend; // R23
					next_rdata[CTRL_ERASE_WRITE_BIT] = combo_pend; // R23
				end
				REG_NVM_STATUS: begin
					next_rdata[ST_ERASE_BUSY_BIT] = state == ST_ERASE; // R07
					next_rdata[ST_PROG_BUSY_BIT] = state == ST_PROG; // R07
					next_rdata[ST_ERASE_DONE_BIT] = erase_done;
					next_rdata[ST_PROG_DONE_BIT] = prog_done;
					next_rdata[ST_CACHE_SHORT_BIT] = cache_short;
					next_rdata[ST_CACHE_FULL_BIT] = cache_full;
				end
				REG_CRC_CTRL: begin
					next_rdata[CRC_RECOMPUTE_BIT] = crc_pend || crc_busy; // R23
				end
				REG_CRC_STATUS: begin
					next_rdata[CRC_BUSY_BIT] = crc_busy || crc_pend; // R10
					next_rdata[CRC_MATCH_BIT] = crc_match; // R10
					next_rdata[CRC_PU_DONE_BIT] = pu_done;
					next_rdata[CRC_CORRUPT_BIT] = crc_corrupt;
				end
				REG_SENSOR_CFG: next_rdata = sensor_cfg;
				REG_OV_LIMIT: next_rdata = ov_limit;
				REG_UV_LIMIT: next_rdata = uv_limit;
				REG_FAULT_STATUS: next_rdata = {1'b0, chain_faults, supply_faults};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule // nvm_page_ctrl

// file: test/nvm_page_ctrl_asserts.sv
`timescale 1ns/1ps
module nvm_page_ctrl_asserts
	import nvm_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic comp_timing_err,
	input wire logic comp_checksum_err,
	input wire logic analog_rail_fault,
	input wire logic digital_rail_fault,
	input wire logic bridge_supply_fault,
	input wire logic osc_supply_fault,
	input wire logic reference_fault,
	input wire logic dac_enable,
	input wire logic comp_reset,
	input wire logic dac_code_zero,
	input wire logic dac_fault_drive,
	input wire logic [7:0] dac_fault_level,
	input wire logic [2:0] open_detect_level,
	input wire logic press_pulldown_off
);
	logic comp_any;
	logic [4:0] rail_v;
	assign comp_any = comp_timing_err | comp_checksum_err;
	assign rail_v = {analog_rail_fault, digital_rail_fault,
		bridge_supply_fault, osc_supply_fault, reference_fault};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_comp_off;
		comp_any && !dac_enable;
	endsequence
	sequence s_rail_drive;
		(|rail_v) && dac_fault_drive;
	endsequence
	a_rdata_idle: assert property ($past(rst_n) && !$past(reg_rd)
		|-> reg_rdata == 8'h00) else $error("read data outside its cycle");
	a_comp_pair: assert property (comp_reset == !dac_enable)
		else $error("comp reset and dac enable disagree");
	a_dac_on: assert property ($past(rst_n) && !$past(comp_any)
		|-> dac_enable) else $error("dac off without error");
	a_comp_hold: assert property (s_comp_off ##1 comp_any
		|-> !dac_enable) else $error("dac back on during error");
	a_rail_hold: assert property (s_rail_drive ##1 (|rail_v)
		|-> dac_fault_drive) else $error("fault drive dropped");
	a_reset_vals: assert property (!$past(rst_n) |-> comp_reset
		&& !dac_enable && dac_code_zero && !dac_fault_drive)
		else $error("wrong fault outputs after reset");
	a_cfg_reset: assert property (!$past(rst_n) |-> dac_fault_level
		== 8'h00 && open_detect_level == 3'h0 && !press_pulldown_off)
		else $error("config outputs not cleared");
	a_fault_status: assert property ($past(rst_n) && $past(reg_rd)
		&& $past(reg_addr) == REG_FAULT_STATUS
		&& $past(rail_v, 2) == $past(rail_v)
		|-> reg_rdata[4:0] == $past(rail_v) && !reg_rdata[7])
		else $error("fault status mismatch");
endmodule // nvm_page_ctrl_asserts
bind nvm_page_ctrl nvm_page_ctrl_asserts chk_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .comp_timing_err(comp_timing_err),
	.comp_checksum_err(comp_checksum_err),
	.analog_rail_fault(analog_rail_fault),
	.digital_rail_fault(digital_rail_fault),
	.bridge_supply_fault(bridge_supply_fault),
	.osc_supply_fault(osc_supply_fault),
	.reference_fault(reference_fault), .dac_enable(dac_enable),
	.comp_reset(comp_reset), .dac_code_zero(dac_code_zero),
	.dac_fault_drive(dac_fault_drive), .dac_fault_level(dac_fault_level),
	.open_detect_level(open_detect_level),
	.press_pulldown_off(press_pulldown_off));

// file: test/test_nvm_page_ctrl.sv
`timescale 1ns/1ps
module test_nvm_page_ctrl;
	import nvm_ctrl_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] comp_err = 2'b00;
	logic [4:0] rails = 5'h00;
	logic [7:0] p_pos = 8'h40;
	logic [7:0] p_neg = 8'h40;
	logic [7:0] reg_rdata, dac_fault_level, d;
	logic dac_enable, comp_reset, dac_code_zero, dac_fault_drive;
	logic pd_lo, pd_hi, pd_off, pu_off;
	logic [2:0] lvl;
	logic [7:0] img [0:127];
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;
	nvm_page_ctrl #(.ERASE_TIME(8), .PROGRAM_TIME(8), .CRC_DEADLINE(200))
		uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .comp_timing_err(comp_err[0]),
		.comp_checksum_err(comp_err[1]), .analog_rail_fault(rails[4]),
		.digital_rail_fault(rails[3]), .bridge_supply_fault(rails[2]),
		.osc_supply_fault(rails[1]), .reference_fault(rails[0]),
		.press_in_pos(p_pos), .press_in_neg(p_neg),
		.dac_enable(dac_enable), .comp_reset(comp_reset),
		.dac_code_zero(dac_code_zero), .dac_fault_drive(dac_fault_drive),
		.dac_fault_level(dac_fault_level), .pulldown_sel_lo(pd_lo),
		.pulldown_sel_hi(pd_hi), .open_detect_level(lvl),
		.press_pulldown_off(pd_off), .temp_pullup_off(pu_off));
	task automatic complete_run();
		$display("compares %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic poll(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] v);
		int i;
		for (i = 0; i < 300; i++) begin
			rd(a);
			if ((d & m) === v) break;
		end
		if (i == 300) begin
			chk(d & m, v);
			complete_run();
		end
	endtask
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	function automatic logic [7:0] crc_img();
		logic [7:0] c;
		c = 8'hff;
		for (int a = 0; a < 127; a++) begin
			c = c ^ img[a];
			for (int b = 0; b < 8; b++) begin
				c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction
	task automatic prog15(input logic [7:0] crc, input logic split);
		wr(REG_PAGE_SELECT, {4'h0, LAST_PAGE});
		for (int k = 0; k < 7; k++) begin
			wr(REG_CACHE_BASE + 8'(k), img[120 + k]);
		end
		wr(REG_CACHE_BASE + 8'h07, crc);
		rd(REG_NVM_STATUS);
		chk(d & 8'h20, 8'h20);
		if (split) begin
			wr(REG_NVM_CTRL, 8'h01);
			rd(REG_NVM_STATUS);
			chk(d & 8'h03, 8'h01);
			poll(REG_NVM_STATUS, 8'h05, 8'h04);
			rd(8'hfc);
			chk(d, ERASED_BYTE);
			wr(REG_NVM_CTRL, 8'h02);
			rd(REG_NVM_STATUS);
			chk(d & 8'h03, 8'h02);
		end else begin
			wr(REG_NVM_CTRL, 8'h04);
			rd(REG_NVM_STATUS);
			chk(d & 8'h03, 8'h01);
			poll(REG_NVM_STATUS, 8'h02, 8'h02);
		end
		poll(REG_NVM_CTRL, 8'h07, 8'h00);
		rd(REG_NVM_STATUS);
		chk(d & 8'h0b, 8'h08);
		poll(REG_CRC_CTRL, 8'h01, 8'h00);
	endtask
	task automatic t_powerup();
		int c0;
		c0 = cyc;
		poll(REG_CRC_STATUS, 8'h04, 8'h04);
		chk({7'h00, (cyc - c0) <= 200}, 8'h01);
		chk(d & 8'h0f, 8'h0c);
		chk({6'h00, dac_enable, dac_code_zero}, 8'h02);
		rd(REG_OV_LIMIT);
		chk(d, OV_LIMIT_RESET);
		rd(8'h09);
		chk(d, 8'h00);
		$display("powerup test done");
	endtask
	task automatic t_bad_crc();
		prog15(8'h00, 1'b0);
		#1 chk({7'h00, dac_code_zero}, 8'h01);
		rd(REG_CRC_STATUS);
		chk(d & 8'h0f, 8'h0c);
		chk(dac_fault_level, 8'h5a);
		chk({1'b0, pu_off, pd_off, lvl, pd_hi, pd_lo}, 8'h6d);
		wr(8'hfe, 8'h00);
		rd(8'hfe);
		chk(d, 8'h6d);
		rd(8'hf0);
		chk(d, 8'h00);
		wr(REG_NVM_CTRL, 8'h02);
		rd(REG_NVM_STATUS);
		chk(d & 8'h13, 8'h10);
		$display("bad checksum test done");
	endtask
	task automatic t_good_crc();
		img[127] = crc_img();
		prog15(img[127], 1'b1);
		rd(REG_CRC_STATUS);
		chk(d & 8'h0f, 8'h06);
		chk({7'h00, dac_code_zero}, 8'h00);
		wr(REG_CRC_CTRL, 8'h01);
		rd(REG_CRC_CTRL);
		chk(d & 8'h01, 8'h01);
		rd(REG_CRC_STATUS);
		chk(d & 8'h01, 8'h01);
		poll(REG_CRC_CTRL, 8'h01, 8'h00);
		rd(REG_CRC_STATUS);
		chk(d & 8'h0f, 8'h06);
		$display("good checksum test done");
	endtask
	task automatic t_faults();
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			comp_err <= 2'(1 << i);
			settle();
			chk({6'h00, dac_enable, comp_reset}, 8'h01);
			@(posedge sys_clk);
			comp_err <= 2'b00;
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			rails <= 5'(1 << i);
			settle();
			chk({7'h00, dac_fault_drive}, 8'h01);
			rd(REG_FAULT_STATUS);
			chk(d, {3'b000, rails});
			@(posedge sys_clk);
			rails <= 5'h00;
		end
		wr(REG_OV_LIMIT, 8'h80);
		p_pos <= 8'h90;
		rd(REG_FAULT_STATUS);
		chk({1'b0, d[6:5], 4'h0, dac_fault_drive}, 8'h21);
		p_pos <= 8'h40;
		wr(REG_UV_LIMIT, 8'h50);
		rd(REG_FAULT_STATUS);
		chk({1'b0, d[6:5], 4'h0, dac_fault_drive}, 8'h41);
		wr(REG_UV_LIMIT, 8'h00);
		settle();
		chk({7'h00, dac_fault_drive}, 8'h00);
		$display("fault test done");
	endtask
	initial begin
		for (int a = 0; a < 128; a++) img[a] = 8'h00;
		for (int a = 120; a < 124; a++) img[a] = 8'(a);
		img[124] = 8'h5a;
		img[125] = 8'h01;
		img[126] = 8'h6d;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_powerup();
		t_bad_crc();
		t_good_crc();
		t_faults();
		complete_run();
	end
endmodule // test_nvm_page_ctrl
